// ### rfm_chan_check.v
`timescale 1ns/1ps
`default_nettype none
`include "rfm_defs.vh"
module rfm_chan_check (
  input wire [15:0] vsense,
  input wire [15:0] target,
  input wire [15:0] vcmd,
  input wire [8:0] uvf_off,
  input wire [8:0] uvw_off,
  input wire [7:0] droop,
  input wire [31:0] iph,
  input wire [2:0] nph,
  input wire [7:0] per_phase_valley_limit,
  input wire [9:0] ocf_lim,
  input wire [9:0] ocw_lim,
  input wire [7:0] share_thr,
  input wire [7:0] temp,
  input wire [7:0] otf_lim,
  input wire [7:0] otw_lim,
  output wire uvf_c,
  output wire uvw_c,
  output wire ton_ok,
  output wire ocf_c,
  output wire ocw_c,
  output wire share_c,
  output wire otf_c,
  output wire otw_c,
  output wire [3:0] ocl_hit
);
  wire [9:0] acc [0:`RFM_NPH];
  wire [`RFM_NPH-1:0] share_p;
  wire [9:0] isum;
  wire [17:0] dr_i;
  wire [17:0] dr_oc;
  wire signed [18:0] sv;
  wire signed [18:0] uvf_trip;
  wire signed [18:0] uvw_trip;
  wire signed [18:0] ton_thr;
  wire [10:0] thrn;

  assign acc[0] = 10'h000;
  genvar p;
  generate
    for (p = 0; p < `RFM_NPH; p = p + 1) begin : g_ph
      localparam [31:0] PW = p;
      localparam [2:0] PIDX = PW[2:0];
      wire [7:0] i = iph[p*8 +: 8];
      wire on = (nph > PIDX);
      wire [10:0] scaled = i * nph;
      assign acc[p+1] = acc[p] + (on ? {2'b00, i} : 10'h000);
      assign ocl_hit[p] = i > per_phase_valley_limit;
      // Deviation scaled by phase count instead of dividing the sum
      assign share_p[p] = on &&
        (({1'b0, scaled} >= ({2'b00, isum} + {1'b0, thrn})) ||
         (({1'b0, scaled} + {1'b0, thrn}) <= {2'b00, isum}));
    end
  endgenerate

  assign isum = acc[`RFM_NPH];
  assign thrn = share_thr * nph;
  assign share_c = |share_p;
  assign dr_i = droop * isum;
  assign dr_oc = droop * ocf_lim;
  assign sv = $signed({3'b000, vsense});
  assign uvf_trip = $signed({3'b000, target}) - $signed({10'h000, uvf_off})
    - $signed({5'h00, dr_i[17:`RFM_DROOP_SHIFT]});
  assign uvw_trip = $signed({3'b000, target}) - $signed({10'h000, uvw_off})
    - $signed({5'h00, dr_i[17:`RFM_DROOP_SHIFT]});
  assign ton_thr = $signed({3'b000, vcmd}) - $signed({10'h000, uvf_off})
    - $signed({5'h00, dr_oc[17:`RFM_DROOP_SHIFT]});
  assign uvf_c = sv < uvf_trip;
  assign uvw_c = sv < uvw_trip;
  assign ton_ok = sv > ton_thr;
  assign ocf_c = isum > ocf_lim;
  assign ocw_c = isum > ocw_lim;
  assign otf_c = temp > otf_lim;
  assign otw_c = temp > otw_lim;
endmodule
`default_nettype wire

// ### rfm_defs.vh
`ifndef RFM_DEFS_VH
`define RFM_DEFS_VH
`define RFM_NCH 2
`define RFM_NPH 4
`define RFM_CLK_PERIOD_NS 20
`define RFM_NS_PER_US 1000
`define RFM_US_CYC (`RFM_NS_PER_US / `RFM_CLK_PERIOD_NS)
`define RFM_DROOP_SHIFT 4
`define RFM_MAP_END 32'h00000080
`define RFM_CH_BIT 6
`define RFM_OFF_VCMD 6'h00
`define RFM_OFF_VMIN 6'h04
`define RFM_OFF_VMAX 6'h08
`define RFM_OFF_UVF 6'h0c
`define RFM_OFF_UVW 6'h10
`define RFM_OFF_OCF 6'h14
`define RFM_OFF_OCW 6'h18
`define RFM_OFF_OTF 6'h1c
`define RFM_OFF_OTW 6'h20
`define RFM_OFF_SHARE 6'h24
`define RFM_OFF_TON 6'h28
`define RFM_OFF_RESP 6'h2c
`define RFM_OFF_DROOP 6'h30
`define RFM_OFF_CFG 6'h34
`define RFM_OFF_STAT 6'h38
`define RFM_OFF_MASK 6'h3c
`define RFM_SEL_TOTAL 8'hff
`define RFM_SEL_PHASE 8'h00
`define RFM_UVF_MIN 9'h020
`define RFM_UVW_MIN 9'h018
`define RFM_UV_MAX 9'h1c0
`define RFM_UVF_STEP_MASK 9'h1e0
`define RFM_UVW_STEP_MASK 9'h1f8
`define RFM_OCL_MIN 8'h11
`define RFM_OCL_MAX 8'h82
`define RFM_OT_MIN 8'h5a
`define RFM_OT_MAX 8'ha0
`define RFM_RST_VMIN 16'h00fa
`define RFM_RST_VMAX 16'h157c
`define RFM_RST_UVF 9'h100
`define RFM_RST_UVW 9'h080
`define RFM_RST_OCLIM 10'h3ff
`define RFM_RST_OCL 8'h82
`define RFM_RST_OTF 8'h91
`define RFM_RST_OTW 8'h7d
`define RFM_RST_SHARE 8'h14
`define RFM_RST_TON 16'h0bb8
`define RFM_RST_NPH 3'h4
`define RFM_ST_UVF 0
`define RFM_ST_UVW 1
`define RFM_ST_TON 2
`define RFM_ST_OOB 3
`define RFM_ST_OCF 4
`define RFM_ST_OCW 5
`define RFM_ST_SHARE 6
`define RFM_ST_OTF 7
`define RFM_ST_OTW 8
`define RFM_NSTAT 9
`define RFM_RSP_UV 0
`define RFM_RSP_TON 1
`define RFM_RSP_OC 2
`define RFM_RSP_OT 3
`endif

// ### rfm_monitor.v
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "rfm_defs.vh"
module rfm_monitor (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire [1:0] ven,
  input wire [31:0] vout_sense,
  input wire [63:0] phase_current,
  input wire [15:0] temperature_sense_input,
  input wire [7:0] pwm_in,
  output wire [7:0] pwm_out,
  output wire [7:0] pwm_oe,
  output wire [31:0] vout_target,
  output reg alert_n
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_WAIT = 3'h1;
  localparam [2:0] ST_RISE = 3'h2;
  localparam [2:0] ST_REG = 3'h3;
  localparam [2:0] ST_SHUT = 3'h4;
  localparam [31:0] US_LAST_W = `RFM_US_CYC - 1;
  localparam [5:0] US_LAST = US_LAST_W[5:0];

  wire in_map = (paddr < `RFM_MAP_END);
  wire wr = psel & penable & pwrite & in_map;
  wire setup = psel & ~penable;
  wire [63:0] rd_ch;
  wire [1:0] alert_ch;
  reg [5:0] tick_cnt;
  wire tick = (tick_cnt == US_LAST);

  assign pready = 1'b1;

  // Offset is rounded down to its step, then limited
  function [8:0] clamp_off;
    input [16:0] d;
    input [1:0] sh;
    input [8:0] lo;
    input [8:0] msk;
    reg [15:0] v;
    reg [8:0] r;
    begin
      v = d[15:0] >> sh;
      r = v[8:0] & msk;
      if (d[16])
        clamp_off = lo;
      else if (v > {7'h00, `RFM_UV_MAX})
        clamp_off = `RFM_UV_MAX;
      else if (r < lo)
        clamp_off = lo;
      else
        clamp_off = r;
    end
  endfunction

  function [7:0] clamp8;
    input [7:0] v;
    input [7:0] lo;
    input [7:0] hi;
    begin
      clamp8 = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tick_cnt <= 6'h00;
    else if (tick)
      tick_cnt <= 6'h00;
    else
      tick_cnt <= tick_cnt + 6'h01;
  end

  genvar c;
  generate
    for (c = 0; c < `RFM_NCH; c = c + 1) begin : g_ch
      localparam CH = c;
      wire wsel = wr & (paddr[`RFM_CH_BIT] == CH[0]);
      reg [15:0] vcmd, vmin, vmax, target, ton_lim, ton_cnt;
      reg [8:0] uvf_off, uvw_off, status, mask;
      reg [9:0] ocf_lim, ocw_lim;
      reg [7:0] per_phase_valley_limit, otf_lim, otw_lim, share_thr, droop;
      reg [3:0] resp, pwm_o, pwm_e;
      reg [1:0] scale;
      reg [2:0] nph, state, next_state;
      reg [31:0] rdv;
      reg [8:0] ev;
      wire uvf_c, uvw_c, ton_ok, ocf_c, ocw_c, share_c, otf_c, otw_c;
      wire [3:0] ocl_hit;
      wire [16:0] dlim = {1'b0, vcmd} - {1'b0, pwdata[15:0]};
      wire [15:0] goal = (vcmd < vmin) ? vmin :
        ((vcmd > vmax) ? vmax : vcmd);
      wire oob_ev = wsel && (paddr[5:0] == `RFM_OFF_VCMD) &&
        ((pwdata[15:0] < vmin) || (pwdata[15:0] > vmax));
      wire uv_en = (state == ST_RISE) || (state == ST_REG);
      wire active = uv_en || (state == ST_WAIT);
      wire ton_ev = (state == ST_RISE) && !ton_ok &&
        (ton_cnt >= ton_lim);
      wire shut_ev = (ev[`RFM_ST_UVF] & ~resp[`RFM_RSP_UV]) |
        (ev[`RFM_ST_TON] & ~resp[`RFM_RSP_TON]) |
        (ev[`RFM_ST_OCF] & ~resp[`RFM_RSP_OC]) |
        (ev[`RFM_ST_OTF] & ~resp[`RFM_RSP_OT]);
      wire next_on = (next_state == ST_WAIT) ||
        (next_state == ST_RISE) || (next_state == ST_REG);
      wire grp_v = |status[`RFM_ST_OOB:`RFM_ST_UVF];
      wire grp_i = |status[`RFM_ST_SHARE:`RFM_ST_OCF];
      wire grp_t = |status[`RFM_ST_OTW:`RFM_ST_OTF];

      rfm_chan_check u_check (
        .vsense(vout_sense[c*16 +: 16]),
        .target(target),
        .vcmd(vcmd),
        .uvf_off(uvf_off),
        .uvw_off(uvw_off),
        .droop(droop),
        .iph(phase_current[c*32 +: 32]),
        .nph(nph),
        .per_phase_valley_limit(per_phase_valley_limit),
        .ocf_lim(ocf_lim),
        .ocw_lim(ocw_lim),
        .share_thr(share_thr),
        .temp(temperature_sense_input[c*8 +: 8]),
        .otf_lim(otf_lim),
        .otw_lim(otw_lim),
        .uvf_c(uvf_c),
        .uvw_c(uvw_c),
        .ton_ok(ton_ok),
        .ocf_c(ocf_c),
        .ocw_c(ocw_c),
        .share_c(share_c),
        .otf_c(otf_c),
        .otw_c(otw_c),
        .ocl_hit(ocl_hit)
      );

      // Event vector, each bit checked for this channel only
      always @* begin
        ev = 9'h000;
        ev[`RFM_ST_UVF] = uv_en & uvf_c;
        ev[`RFM_ST_UVW] = uv_en & uvw_c;
        ev[`RFM_ST_TON] = ton_ev;
        ev[`RFM_ST_OOB] = oob_ev;
        ev[`RFM_ST_OCF] = active & ocf_c;
        ev[`RFM_ST_OCW] = active & ocw_c;
        ev[`RFM_ST_SHARE] = active & share_c;
        ev[`RFM_ST_OTF] = active & otf_c;
        ev[`RFM_ST_OTW] = active & otw_c;
      end

      always @* begin
        next_state = state;
        case (state)
          ST_IDLE: begin
            if (ven[c])
              next_state = ST_WAIT;
          end
          ST_WAIT: begin
            if (!ven[c])
              next_state = ST_IDLE;
            else if (shut_ev)
              next_state = ST_SHUT;
            else if (|pwm_in[c*4 +: 4])
              next_state = ST_RISE;
          end
          ST_RISE: begin
            if (!ven[c])
              next_state = ST_IDLE;
            else if (shut_ev)
              next_state = ST_SHUT;
            else if (ton_ok)
              next_state = ST_REG;
          end
          ST_REG: begin
            if (!ven[c])
              next_state = ST_IDLE;
            else if (shut_ev)
              next_state = ST_SHUT;
          end
          ST_SHUT: begin
            if (!ven[c])
              next_state = ST_IDLE;
          end
          default: next_state = ST_IDLE;
        endcase
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          state <= ST_IDLE;
          ton_cnt <= 16'h0000;
          target <= 16'h0000;
          pwm_o <= 4'h0;
          pwm_e <= 4'h0;
          status <= 9'h000;
        end else begin
          state <= next_state;
          if (state != ST_RISE)
            ton_cnt <= 16'h0000;
          else if (tick && ton_cnt != 16'hffff)
            ton_cnt <= ton_cnt + 16'h0001;
          if (tick && target < goal)
            target <= target + 16'h0001;
          else if (tick && target > goal)
            target <= target - 16'h0001;
          pwm_e <= {4{next_on}};
          pwm_o <= pwm_in[c*4 +: 4] & ~ocl_hit & {4{next_on}};
          if (wsel && paddr[5:0] == `RFM_OFF_STAT)
            status <= (status & ~pwdata[8:0]) | ev;
          else
            status <= status | ev;
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          vcmd <= 16'h0000;
          vmin <= `RFM_RST_VMIN;
          vmax <= `RFM_RST_VMAX;
          uvf_off <= `RFM_RST_UVF;
          uvw_off <= `RFM_RST_UVW;
          ocf_lim <= `RFM_RST_OCLIM;
          ocw_lim <= `RFM_RST_OCLIM;
          per_phase_valley_limit <= `RFM_RST_OCL;
          otf_lim <= `RFM_RST_OTF;
          otw_lim <= `RFM_RST_OTW;
          share_thr <= `RFM_RST_SHARE;
          ton_lim <= `RFM_RST_TON;
          resp <= 4'h0;
          droop <= 8'h00;
          scale <= 2'h0;
          nph <= `RFM_RST_NPH;
          mask <= 9'h000;
        end else if (wsel) begin
          case (paddr[5:0])
            `RFM_OFF_VCMD: vcmd <= pwdata[15:0];
            `RFM_OFF_VMIN: vmin <= pwdata[15:0];
            `RFM_OFF_VMAX: vmax <= pwdata[15:0];
            `RFM_OFF_UVF: uvf_off <= clamp_off(dlim, scale,
              `RFM_UVF_MIN, `RFM_UVF_STEP_MASK);
            `RFM_OFF_UVW: uvw_off <= clamp_off(dlim, scale,
              `RFM_UVW_MIN, `RFM_UVW_STEP_MASK);
            `RFM_OFF_OCF: begin
              if (pwdata[23:16] == `RFM_SEL_TOTAL)
                ocf_lim <= pwdata[9:0];
              else if (pwdata[23:16] == `RFM_SEL_PHASE)
                per_phase_valley_limit <= clamp8(pwdata[7:0], `RFM_OCL_MIN,
                  `RFM_OCL_MAX);
            end
            `RFM_OFF_OCW: ocw_lim <= pwdata[9:0];
            `RFM_OFF_OTF: otf_lim <= clamp8(pwdata[7:0], `RFM_OT_MIN,
              `RFM_OT_MAX);
            `RFM_OFF_OTW: otw_lim <= clamp8(pwdata[7:0], `RFM_OT_MIN,
              `RFM_OT_MAX);
            `RFM_OFF_SHARE: share_thr <= pwdata[7:0];
            `RFM_OFF_TON: ton_lim <= pwdata[15:0];
            `RFM_OFF_RESP: resp <= pwdata[3:0];
            `RFM_OFF_DROOP: droop <= pwdata[7:0];
            `RFM_OFF_CFG: begin
              scale <= pwdata[1:0];
              nph <= (pwdata[6:4] == 3'h0 || pwdata[6:4] > `RFM_RST_NPH) ?
                `RFM_RST_NPH : pwdata[6:4];
            end
            `RFM_OFF_MASK: mask <= pwdata[8:0];
            default: mask <= mask;
          endcase
        end
      end

      always @* begin
        rdv = 32'h00000000;
        case (paddr[5:0])
          `RFM_OFF_VCMD: rdv = {target, vcmd};
          `RFM_OFF_VMIN: rdv = {16'h0000, vmin};
          `RFM_OFF_VMAX: rdv = {16'h0000, vmax};
          `RFM_OFF_UVF: rdv = {16'h0000, vcmd - {7'h00, uvf_off}};
          `RFM_OFF_UVW: rdv = {16'h0000, vcmd - {7'h00, uvw_off}};
          `RFM_OFF_OCF: rdv = {per_phase_valley_limit, 14'h0000, ocf_lim};
          `RFM_OFF_OCW: rdv = {22'h000000, ocw_lim};
          `RFM_OFF_OTF: rdv = {24'h000000, otf_lim};
          `RFM_OFF_OTW: rdv = {24'h000000, otw_lim};
          `RFM_OFF_SHARE: rdv = {24'h000000, share_thr};
          `RFM_OFF_TON: rdv = {ton_cnt, ton_lim};
          `RFM_OFF_RESP: rdv = {25'h0000000, state, resp};
          `RFM_OFF_DROOP: rdv = {24'h000000, droop};
          `RFM_OFF_CFG: rdv = {25'h0000000, nph, 2'h0, scale};
          `RFM_OFF_STAT: rdv = {16'h0000, grp_v | grp_i | grp_t,
            grp_t, grp_i, grp_v, 3'h0, status};
          `RFM_OFF_MASK: rdv = {23'h000000, mask};
          default: rdv = 32'h00000000;
        endcase
      end

      assign rd_ch[c*32 +: 32] = rdv;
      assign alert_ch[c] = |(status & ~mask);
      assign pwm_out[c*4 +: 4] = pwm_o;
      assign pwm_oe[c*4 +: 4] = pwm_e;
      assign vout_target[c*16 +: 16] = target;
    end
  endgenerate

  // Read data captured in the setup cycle, so access needs no wait
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      alert_n <= 1'b1;
    end else begin
      if (setup) begin
        pslverr <= ~in_map;
        if (!in_map || pwrite)
          prdata <= 32'h00000000;
        else if (paddr[`RFM_CH_BIT])
          prdata <= rd_ch[63:32];
        else
          prdata <= rd_ch[31:0];
      end
      alert_n <= ~(|alert_ch);
    end
  end
endmodule
`default_nettype wire

// ### rfm_monitor_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module rfm_monitor_assertions (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [1:0] ven,
  input wire [63:0] phase_current,
  input wire [15:0] temperature_sense_input,
  input wire [7:0] pwm_in,
  input wire [7:0] pwm_out,
  input wire [7:0] pwm_oe,
  input wire [31:0] vout_target,
  input wire alert_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pwrite;
  sequence s_ch1_on;
    ven[1] && $past(ven[1]);
  endsequence
  sequence s_ch1_fall;
    $fell(pwm_oe[4]) ##0 s_ch1_on;
  endsequence
  a_alert_sticky: assert property (
    !alert_n && !wr && !$past(wr) |=> !alert_n)
    else $error("alert released without a host write");
  a_valley_gate: assert property (
    phase_current[7:0] > 8'h82 |=> !pwm_out[0])
    else $error("pulse passed above the valley limit");
  a_pwm_follow: assert property (
    pwm_out[4] |-> $past(pwm_in[4]))
    else $error("pulse out without a pulse in");
  a_target_max: assert property (
    vout_target[15:0] <= 16'h157c && vout_target[31:16] <= 16'h157c)
    else $error("target beyond the maximum");
  a_heat_shut: assert property (
    temperature_sense_input[15:8] > 8'ha0 && pwm_oe[4] |=> !pwm_oe[4])
    else $error("rail kept driving when too hot");
  a_shut_alert: assert property (
    s_ch1_fall |=> !alert_n)
    else $error("shutdown without alert");
  a_shut_sticky: assert property (
    s_ch1_on ##0 !pwm_oe[4] |=> !pwm_oe[4])
    else $error("shut rail restarted while enabled");
  a_chan_apart: assert property (
    s_ch1_fall |-> $stable(pwm_oe[3:0]))
    else $error("other channel disturbed by shutdown");
endmodule
bind rfm_monitor rfm_monitor_assertions i_rfm_monitor_assertions (
  .pclk, .presetn, .psel, .penable, .pwrite, .ven, .phase_current,
  .temperature_sense_input, .pwm_in, .pwm_out, .pwm_oe, .vout_target,
  .alert_n);
`default_nettype wire

// ### rfm_monitor_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rfm_monitor_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, rd, v, ph, n0, n1;
  logic [31:0] seed = 60;
  logic [1:0] ven = 0, grow = 0;
  logic [63:0] cur = 0;
  logic [15:0] tmp = 0;
  logic slverr;
  wire [31:0] prdata, vout_sense;
  wire [7:0] pwm_in, pwm_out, pwm_oe;
  wire pready, pslverr, alert_n;
  int num_errors = 0, n_tests = 0, k, t;
  rfm_monitor i_rfm_monitor (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .ven, .vout_sense,
    .phase_current(cur), .temperature_sense_input(tmp), .pwm_in,
    .pwm_out, .pwm_oe, .vout_target(), .alert_n);
  rfm_stage_model i_rfm_stage_model (.pclk, .presetn, .grow, .pwm_oe,
    .pwm_in, .vout_sense);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [8:0] ioexp(logic [31:0] p, logic [9:0] l,
                                       logic [7:0] h);
    int s, d, q;
    logic [8:0] f;
    q = h;
    s = p[7:0] + p[15:8] + p[23:16] + p[31:24];
    f = 9'h0;
    f[5] = s > l;
    for (int i = 0; i < 4; i++) begin
      d = 4 * p[i*8 +: 8] - s;
      if (d >= 4 * q || -d >= 4 * q) f[6] = 1'b1;
    end
    return f;
  endfunction
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    int j;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    j = 0;
    do begin
      @(posedge pclk);
      j++;
    end while (pready !== 1'b1 && j < 40);
    rd = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (j >= 40) begin
      num_errors++;
      end_of_test();
    end
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [31:0] a, m, e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  task automatic achk(input logic e);
    @(negedge pclk);
    chk({31'h0, alert_n}, {31'h0, e});
    @(posedge pclk);
  endtask
  task automatic waitst(input logic [31:0] a, input int b);
    int j;
    for (j = 0; j < 300; j++) begin
      apb(1'b0, a, 32'h0);
      if (rd[b] === 1'b1) break;
    end
    chk({31'h0, rd[b]}, 32'h1);
    if (j == 300) end_of_test();
  endtask
  task automatic chkio(input logic [31:0] p, input logic [9:0] l,
                       input logic [7:0] h);
    logic [8:0] e;
    e = ioexp(p, l, h);
    rdchk(32'h78, 32'h60, {23'h0, e});
    achk(e == 9'h0);
    chk({31'h0, pwm_oe[4]}, 32'h1);
  endtask
  initial begin
    forever #10 pclk = ~pclk;
  end
  initial begin
    repeat (100000) @(posedge pclk);
    num_errors++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(32'h04, 32'hffff, 32'h00fa);
    rdchk(32'h1c, 32'hff, 32'h91);
    apb(1'b1, 32'h14, 32'h5);
    rdchk(32'h14, 32'hff000000, 32'h11000000);
    v = (rnd() & 32'h3ff) | 32'h100;
    apb(1'b1, 32'h14, 32'h00ff0000 | v);
    rdchk(32'h14, 32'h3ff, v);
    apb(1'b0, 32'h80 + (rnd() & 32'h3c), 32'h0);
    chk({31'h0, slverr}, 32'h1);
    chk(rd, 32'h0);
    $display("test regs done");
    apb(1'b1, 32'h2c, 32'h3);
    apb(1'b1, 32'h30, 32'h0);
    apb(1'b1, 32'h70, 32'h0);
    apb(1'b1, 32'h00, 32'd6000);
    rdchk(32'h38, 32'h8, 32'h8);
    achk(1'b0);
    apb(1'b1, 32'h3c, 32'h1ff);
    apb(1'b1, 32'h40, 32'd300);
    for (k = 0; k < 6000 && rd[31:16] !== 16'd300; k++)
      apb(1'b0, 32'h40, 32'h0);
    chk({16'h0, rd[31:16]}, 32'd300);
    if (k == 6000) end_of_test();
    v = 32 * (1 + rnd() % 9);
    apb(1'b1, 32'h4c, 32'd300 - v);
    apb(1'b1, 32'h40, 32'd310);
    rdchk(32'h4c, 32'hffff, 32'd310 - v);
    apb(1'b1, 32'h4c, 32'd290);
    rdchk(32'h4c, 32'hffff, 32'd278);
    apb(1'b1, 32'h50, 32'd300);
    rdchk(32'h50, 32'hffff, 32'd286);
    $display("test limits done");
    ven[1] <= 1'b1;
    waitst(32'h78, 0);
    rdchk(32'h78, 32'h4, 32'h0);
    chk({24'h0, pwm_oe}, 32'h0);
    ven[1] <= 1'b0;
    apb(1'b1, 32'h78, 32'h1ff);
    apb(1'b1, 32'h6c, 32'h1);
    apb(1'b1, 32'h68, 32'd2);
    ven[1] <= 1'b1;
    rdchk(32'h78, 32'h4, 32'h0);
    waitst(32'h78, 2);
    chk({28'h0, pwm_oe[7:4]}, 32'h0);
    ven[1] <= 1'b0;
    grow <= 2'h3;
    apb(1'b1, 32'h78, 32'h1ff);
    ven <= 2'h3;
    repeat (150) @(posedge pclk);
    rdchk(32'h6c, 32'h70, 32'h30);
    rdchk(32'h78, 32'h4, 32'h0);
    $display("test rise done");
    cur <= {32'h0, 24'h050505, 8'd131 + 8'(rnd() % 100)};
    n0 = 0;
    n1 = 0;
    @(posedge pclk);
    repeat (40) begin
      @(negedge pclk);
      n0 = n0 + pwm_out[0];
      n1 = n1 + pwm_out[1];
    end
    @(posedge pclk);
    chk(n0, 32'h0);
    chk({31'h0, n1 > 0}, 32'h1);
    $display("test valley done");
    v = 20 + rnd() % 40;
    ph = {4{v[7:0]}};
    cur <= {ph, 32'h0};
    apb(1'b1, 32'h58, 4 * v);
    apb(1'b1, 32'h64, 32'hff);
    apb(1'b1, 32'h78, 32'h1ff);
    chkio(ph, 10'(4 * v), 8'hff);
    apb(1'b1, 32'h58, 4 * v - 1);
    apb(1'b1, 32'h78, 32'h1ff);
    chkio(ph, 10'(4 * v - 1), 8'hff);
    apb(1'b1, 32'h58, 32'h3ff);
    for (t = 0; t < 3; t++) begin
      ph = {4{v[7:0]}};
      ph[7:0] = (t == 2) ? v - 20 : v + 20;
      cur <= {ph, 32'h0};
      apb(1'b1, 32'h64, (t == 1) ? 32'd16 : 32'd15);
      apb(1'b1, 32'h78, 32'h1ff);
      chkio(ph, 10'h3ff, (t == 1) ? 8'd16 : 8'd15);
    end
    apb(1'b1, 32'h54, 32'h00ff0000 | (4 * v - 21));
    waitst(32'h78, 4);
    chk({28'h0, pwm_oe[7:4]}, 32'h0);
    chk({28'h0, pwm_oe[3:0]}, 32'hf);
    ven[1] <= 1'b0;
    apb(1'b1, 32'h54, 32'h00ff03ff);
    ven[1] <= 1'b1;
    repeat (60) @(posedge pclk);
    rdchk(32'h6c, 32'h70, 32'h30);
    $display("test current done");
    cur <= 64'h0;
    tmp <= {8'd126 + 8'(rnd() % 19), 8'h0};
    apb(1'b1, 32'h78, 32'h1ff);
    rdchk(32'h78, 32'h180, 32'h100);
    chk({31'h0, pwm_oe[4]}, 32'h1);
    achk(1'b0);
    apb(1'b1, 32'h7c, 32'h100);
    achk(1'b1);
    apb(1'b1, 32'h7c, 32'h0);
    tmp <= {8'd161 + 8'(rnd() % 40), 8'h0};
    waitst(32'h78, 7);
    chk({28'h0, pwm_oe[7:4]}, 32'h0);
    chk({28'h0, pwm_oe[3:0]}, 32'hf);
    $display("test heat done");
    end_of_test();
  end
endmodule
`default_nettype wire

// ### rfm_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
module rfm_stage_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] grow,
  input wire logic [7:0] pwm_oe,
  output logic [7:0] pwm_in,
  output logic [31:0] vout_sense
);
  logic [2:0] div;
  // Output climbs only while driven; collapses at once when released
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 3'h0;
      pwm_in <= 8'h00;
      vout_sense <= 32'h0;
    end else begin
      div <= div + 3'h1;
      pwm_in <= (div == 3'h0) ? 8'hff : 8'h00;
      for (int c = 0; c < 2; c++) begin
        if (pwm_oe[c*4] && grow[c] && !vout_sense[c*16+15])
          vout_sense[c*16 +: 16] <= vout_sense[c*16 +: 16] + 16'h10;
        else if (!pwm_oe[c*4])
          vout_sense[c*16 +: 16] <= 16'h0;
      end
    end
  end
endmodule
`default_nettype wire
